// [osgh_pkg.sv]
package osgh_pkg;
    // Command codes and result codes
    localparam logic [7:0]  OPC_SET_STATES      = 8'h39;
    localparam logic [7:0]  OPC_READ_STATES     = 8'h3A;
    localparam logic [7:0]  RC_SUCCESS          = 8'h00;
    localparam logic [7:0]  RC_ERROR            = 8'h01;
    localparam logic [7:0]  RC_INVALID_DATA     = 8'h02;
    localparam logic [7:0]  RC_INVALID_LENGTH   = 8'h03;
    localparam logic [7:0]  RC_UNSUPPORTED_CMD  = 8'h05;
    localparam logic [7:0]  RC_UNKNOWN_HANDLE   = 8'h80;
    // Change request flag values
    localparam logic [7:0]  FLAG_LEAVE_UNCHANGED = 8'h00;
    localparam logic [7:0]  FLAG_APPLY_REQUEST   = 8'h01;
    // Operational conditions of one output
    localparam logic [7:0]  COND_UPDATE_PENDING_A    = 8'h00;
    localparam logic [7:0]  COND_NO_UPDATE_PENDING_B = 8'h01;
    localparam logic [7:0]  COND_DISABLED            = 8'h02; // [RULE13]
    localparam logic [7:0]  COND_UNAVAILABLE         = 8'h03;
    // Reserved handles and group limits
    localparam logic [15:0] HANDLE_RSV_LOW  = 16'h0000;
    localparam logic [15:0] HANDLE_RSV_HIGH = 16'hFFFF;
    localparam logic [3:0]  GROUP_MIN       = 4'h1;
    localparam logic [3:0]  GROUP_MAX       = 4'h8;
    localparam logic [1:0]  FIELD_LAST      = 2'h2;

    typedef enum logic [3:0] {
        S_IDLE  = 4'b0000,
        S_HLO   = 4'b0001,
        S_HHI   = 4'b0011,
        S_CNT   = 4'b0010,
        S_FLAG  = 4'b0110,
        S_VAL   = 4'b0111,
        S_SKIP  = 4'b0101,
        S_RESP  = 4'b0100,
        S_DRAIN = 4'b1100
    } osgh_fsm_type;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } osgh_byte_type;

    typedef struct packed {
        osgh_fsm_type     st;
        logic             req_ready;
        logic             is_set;
        logic             bad_opc;
        logic [15:0]      handle;
        logic [3:0]       cnt;
        logic [2:0]       pos;
        logic [1:0]       fld;
        logic [1:0]       phase;
        logic [7:0]       rc;
        logic [7:0]       stg_req;
        logic [7:0][7:0]  stg_val;
        logic [7:0][7:0]  cur;
        osgh_byte_type    resp;
    } osgh_state_type;
endpackage

// [osgh_handler.sv]
`timescale 1ns/100ps
// Summary of operation
// (RULE1) Leave-unchanged flag keeps output state
// (RULE2) Apply-request flag drives output to value
// (RULE3) State value is eight bits, set-defined
// (RULE4) Requester sends handle, never reserved values
// (RULE5) Response starts with result code
// (RULE6) Then group count one to eight
// (RULE7) Then condition, pending, current per output
// (RULE8) Pending shows requested or present state
// (RULE9) Pending Unknown unless an enabled condition
// (RULE10) Current shows state, Unknown unless enabled
// (RULE11) Requester ignores fields unless enabled
// (RULE12) First record field is output condition
// (RULE13) Disabled condition encodes as two
// (RULE14) Records ordered from position zero upward
module osgh_handler #(
    parameter logic [15:0] OUR_HANDLE    = 16'h0001,
    parameter logic [3:0]  GROUP_COUNT   = 4'h8,
    parameter logic [7:0]  UNKNOWN_STATE = 8'h00
) (
    input  wire logic                  sys_clk_in,
    input  wire logic                  reset_n_in,
    input  wire osgh_pkg::osgh_byte_type req_in,
    output      logic                  req_ready_out,
    output      osgh_pkg::osgh_byte_type resp_out,
    input  wire logic                  resp_ready_in,
    input  wire logic [7:0][7:0]       op_cond_in,
    output      logic [7:0][7:0]       state_out
);
    osgh_pkg::osgh_state_type s_r;
    osgh_pkg::osgh_state_type s_nxt;
    logic                     take;
    logic                     commit;
    logic [7:0]               cond;
    logic                     enabled;

    assign take = req_in.valid && s_r.req_ready;
    // Condition of the output whose record is being sent
    assign cond    = op_cond_in[s_r.pos];
    assign enabled = (cond == osgh_pkg::COND_UPDATE_PENDING_A) ||
                     (cond == osgh_pkg::COND_NO_UPDATE_PENDING_B);

    // Parser, commit and response sequencer
    always_comb begin
        s_nxt  = s_r;
        commit = 1'b0;
        case (s_r.st)
            osgh_pkg::S_IDLE: begin
                s_nxt.rc = osgh_pkg::RC_SUCCESS;
                if (take) begin
                    s_nxt.is_set  = (req_in.data == osgh_pkg::OPC_SET_STATES);
                    s_nxt.bad_opc = (req_in.data != osgh_pkg::OPC_SET_STATES) &&
                                    (req_in.data != osgh_pkg::OPC_READ_STATES);
                    s_nxt.stg_req = '0;
                    s_nxt.pos     = '0;
                    s_nxt.st      = osgh_pkg::S_HLO;
                    if (req_in.last) begin
                        s_nxt.rc = osgh_pkg::RC_INVALID_LENGTH;
                        s_nxt.st = osgh_pkg::S_RESP;
                    end
                end
            end
            osgh_pkg::S_HLO: begin
                if (take) begin
                    s_nxt.handle[7:0] = req_in.data;
                    s_nxt.st          = osgh_pkg::S_HHI;
                    if (req_in.last) begin
                        s_nxt.rc = osgh_pkg::RC_INVALID_LENGTH;
                        s_nxt.st = osgh_pkg::S_RESP;
                    end
                end
            end
            osgh_pkg::S_HHI: begin
                if (take) begin
                    s_nxt.handle[15:8] = req_in.data;
                    s_nxt.st           = s_r.is_set ? osgh_pkg::S_CNT : osgh_pkg::S_SKIP;
                    // Read carries only the handle [RULE4]
                    if (req_in.last) begin
                        s_nxt.st = osgh_pkg::S_RESP;
                        if (s_r.is_set)
                            s_nxt.rc = osgh_pkg::RC_INVALID_LENGTH;
                    end else if (!s_r.is_set) begin
                        s_nxt.rc = osgh_pkg::RC_INVALID_LENGTH;
                    end
                end
            end
            osgh_pkg::S_CNT: begin
                if (take) begin
                    s_nxt.cnt = req_in.data[3:0];
                    s_nxt.st  = osgh_pkg::S_FLAG;
                    if (req_in.data < {4'h0, osgh_pkg::GROUP_MIN} ||
                        req_in.data > {4'h0, GROUP_COUNT}) begin
                        s_nxt.rc = osgh_pkg::RC_INVALID_DATA;
                        s_nxt.st = osgh_pkg::S_SKIP;
                    end
                    if (req_in.last) begin
                        s_nxt.rc = osgh_pkg::RC_INVALID_LENGTH;
                        s_nxt.st = osgh_pkg::S_RESP;
                    end
                end
            end
            osgh_pkg::S_FLAG: begin
                if (take) begin
                    // Only the apply value stages a change [RULE1] [RULE2]
                    s_nxt.stg_req[s_r.pos] = (req_in.data == osgh_pkg::FLAG_APPLY_REQUEST);
                    s_nxt.st               = osgh_pkg::S_VAL;
                    if (req_in.data != osgh_pkg::FLAG_APPLY_REQUEST &&
                        req_in.data != osgh_pkg::FLAG_LEAVE_UNCHANGED) begin
                        s_nxt.rc = osgh_pkg::RC_INVALID_DATA;
                        s_nxt.st = osgh_pkg::S_SKIP;
                    end
                    if (req_in.last) begin
                        s_nxt.rc = osgh_pkg::RC_INVALID_LENGTH;
                        s_nxt.st = osgh_pkg::S_RESP;
                    end
                end
            end
            osgh_pkg::S_VAL: begin
                if (take) begin
                    // Value taken as is; its coding belongs to the output's state set [RULE3]
                    s_nxt.stg_val[s_r.pos] = req_in.data;
                    s_nxt.pos              = s_r.pos + 3'd1;
                    s_nxt.st               = osgh_pkg::S_FLAG;
                    // Records arrive from position zero upward [RULE14]
                    if ({1'b0, s_r.pos} == s_r.cnt - 4'd1) begin
                        s_nxt.st = osgh_pkg::S_SKIP;
                        if (req_in.last)
                            s_nxt.st = osgh_pkg::S_RESP;
                        else
                            s_nxt.rc = osgh_pkg::RC_INVALID_LENGTH;
                    end else if (req_in.last) begin
                        s_nxt.rc = osgh_pkg::RC_INVALID_LENGTH;
                        s_nxt.st = osgh_pkg::S_RESP;
                    end
                end
            end
            osgh_pkg::S_SKIP: begin
                // Surplus bytes are drained up to the last one
                if (take && req_in.last)
                    s_nxt.st = osgh_pkg::S_RESP;
            end
            osgh_pkg::S_RESP: begin
                // Result priority: command, handle, then parse result [RULE5]
                if (s_r.phase == 2'd0) begin
                    if (s_r.bad_opc)
                        s_nxt.rc = osgh_pkg::RC_UNSUPPORTED_CMD;
                    else if (s_r.handle != OUR_HANDLE || s_r.handle == osgh_pkg::HANDLE_RSV_LOW ||
                             s_r.handle == osgh_pkg::HANDLE_RSV_HIGH)
                        s_nxt.rc = osgh_pkg::RC_UNKNOWN_HANDLE;
                    s_nxt.phase = 2'd1;
                    s_nxt.pos   = '0;
                    s_nxt.fld   = '0;
                end else if (!s_r.resp.valid || resp_ready_in) begin
                    s_nxt.resp.valid = 1'b1;
                    s_nxt.resp.last  = 1'b0;
                    case (s_r.phase)
                        2'd1: begin
                            s_nxt.resp.data = s_r.rc;
                            s_nxt.phase     = 2'd2;
                            if (s_r.rc != osgh_pkg::RC_SUCCESS || s_r.is_set) begin
                                s_nxt.resp.last = 1'b1;
                                s_nxt.st        = osgh_pkg::S_DRAIN;
                                commit          = s_r.is_set && s_r.rc == osgh_pkg::RC_SUCCESS;
                            end
                        end
                        2'd2: begin
                            s_nxt.resp.data = {4'h0, GROUP_COUNT}; // [RULE6]
                            s_nxt.phase     = 2'd3;
                        end
                        default: begin
                            // Condition, pending, current per output [RULE7] [RULE12]
                            case (s_r.fld)
                                2'd0: s_nxt.resp.data = cond;
                                // Pending and current report Unknown outside enabled [RULE8] [RULE9] [RULE10]
                                default: s_nxt.resp.data = enabled ? s_r.cur[s_r.pos] : UNKNOWN_STATE;
                            endcase
                            s_nxt.fld = s_r.fld + 2'd1;
                            if (s_r.fld == osgh_pkg::FIELD_LAST) begin
                                s_nxt.fld = '0;
                                s_nxt.pos = s_r.pos + 3'd1; // [RULE14]
                                if ({1'b0, s_r.pos} == GROUP_COUNT - 4'd1) begin
                                    s_nxt.resp.last = 1'b1;
                                    s_nxt.st        = osgh_pkg::S_DRAIN;
                                end
                            end
                        end
                    endcase
                end
            end
            osgh_pkg::S_DRAIN: begin
                if (resp_ready_in) begin
                    s_nxt.resp  = '0;
                    s_nxt.phase = 2'd0;
                    s_nxt.st    = osgh_pkg::S_IDLE;
                end
            end
            default: s_nxt.st = osgh_pkg::S_IDLE;
        endcase
        // Staged records land together so a rejected request changes nothing
        if (commit) begin
            for (int i = 0; i < 8; i++) begin
                if (s_r.stg_req[i])
                    s_nxt.cur[i] = s_r.stg_val[i]; // [RULE2]
            end
        end
        s_nxt.req_ready = (s_nxt.st != osgh_pkg::S_RESP) && (s_nxt.st != osgh_pkg::S_DRAIN);
    end

    // State register
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign req_ready_out = s_r.req_ready;
    assign resp_out      = s_r.resp;
    assign state_out     = s_r.cur;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence rec_cond_byte;
        s_r.st == osgh_pkg::S_RESP && s_r.phase == 2'd3 && s_r.fld == 2'd0 && (!s_r.resp.valid || resp_ready_in);
    endsequence

    a_leave_unchanged: assert property (commit && !s_r.stg_req[0] |=> $stable(state_out[0])) // [RULE1]
        else $error("Output changed without apply request");
    a_apply_value: assert property (commit && s_r.stg_req[0] |=> state_out[0] == $past(s_r.stg_val[0])) // [RULE2]
        else $error("Applied value not driven");
    // Checked on the outputs, not on the commit strobe, so a broken strobe is caught
    a_no_commit_fail: assert property (s_r.st == osgh_pkg::S_RESP && s_r.phase != 2'd0 && // [RULE1]
        s_r.rc != osgh_pkg::RC_SUCCESS |=> $stable(state_out))
        else $error("Rejected request changed outputs");
    a_rc_first: assert property (s_r.st == osgh_pkg::S_IDLE && take ##1 !take[*1] ##0 1 |-> !s_r.resp.valid) // [RULE5]
        else $error("Response byte before result");
    a_bad_handle: assert property (s_r.st == osgh_pkg::S_RESP && s_r.phase == 2'd0 && !s_r.bad_opc &&
        s_r.handle != OUR_HANDLE |=> s_r.rc == osgh_pkg::RC_UNKNOWN_HANDLE) // [RULE5]
        else $error("Unknown handle not reported");
    a_count_byte: assert property (s_r.resp.valid && resp_ready_in && s_r.phase == 2'd2 && !s_r.resp.last
        |=> s_r.resp.data == {4'h0, GROUP_COUNT}) // [RULE6]
        else $error("Group count byte wrong");
    a_cond_field: assert property (rec_cond_byte |=> s_r.resp.data == $past(cond)) // [RULE12]
        else $error("Condition field wrong");
    a_unknown_fill: assert property (s_r.st == osgh_pkg::S_RESP && s_r.phase == 2'd3 && s_r.fld != 2'd0 &&
        !enabled && (!s_r.resp.valid || resp_ready_in) |=> s_r.resp.data == UNKNOWN_STATE) // [RULE9]
        else $error("Unknown not reported");
    a_pending_value: assert property (s_r.st == osgh_pkg::S_RESP && s_r.phase == 2'd3 && s_r.fld == 2'd1 && enabled &&
        (!s_r.resp.valid || resp_ready_in) |=> s_r.resp.data == $past(s_r.cur[s_r.pos])) // [RULE8] [RULE10]
        else $error("Pending field wrong");
    // Disabled outputs get the fill value, independent of the enabled decode
    a_disabled_code: assert property (s_r.st == osgh_pkg::S_RESP && s_r.phase == 2'd3 && s_r.fld != 2'd0 && // [RULE13]
        cond == osgh_pkg::COND_DISABLED && (!s_r.resp.valid || resp_ready_in) |=> s_r.resp.data == UNKNOWN_STATE)
        else $error("Disabled output not reported as unknown");
    a_record_order: assert property (rec_cond_byte ##1 (s_r.fld == 2'd1)[*1] |-> s_r.pos == $past(s_r.pos)) // [RULE14]
        else $error("Record order broken");
endmodule

// [osgh_ctrl_model.sv]
`timescale 1ns/100ps
module osgh_ctrl_model (
    input  wire logic                    sys_clk_in,
    input  wire logic                    req_ready_in,
    output      osgh_pkg::osgh_byte_type req_out,
    output      logic                    resp_ready_out
);
    logic slow_r = 1'b0;

    // Idle bus at time zero
    initial begin
        req_out = '0;
        resp_ready_out = 1'b0;
    end

    // Slow mode stalls response acceptance at random
    always @(posedge sys_clk_in) begin
        resp_ready_out <= !slow_r || ($urandom_range(0, 2) == 0);
    end

    // Whole message, each byte held until taken; call just after an edge
    task automatic send(input logic [7:0] msg[$]);
        logic tk;
        foreach (msg[i]) begin
            req_out <= '{1'b1, i == msg.size() - 1, msg[i]};
            do begin
                @(negedge sys_clk_in);
                tk = req_ready_in;
                @(posedge sys_clk_in);
            end while (!tk);
        end
        // Released data shows no stale byte
        req_out <= '{1'b0, 1'b0, ~msg[msg.size() - 1]};
    endtask
endmodule

// [output_state_set_get_handler_tb.sv]
`timescale 1ns/100ps
module output_state_set_get_handler_tb;
    localparam logic [15:0] HANDLE = 16'h0042;
    localparam logic [3:0]  GCNT   = 4'h6;
    localparam logic [7:0]  UNK    = 8'h5A;
    logic                    sys_clk_in;
    logic                    reset_n_in;
    osgh_pkg::osgh_byte_type req;
    osgh_pkg::osgh_byte_type resp;
    logic                    req_ready;
    logic                    resp_ready;
    logic [7:0][7:0]         op_cond;
    logic [7:0][7:0]         state;
    logic [8:0]              exp_q[$];
    logic [7:0]              exp_st[8];
    logic [7:0]              fv[$];
    int                      fails;
    int                      n_checks;
    int                      cycles;

    osgh_handler #(.OUR_HANDLE(HANDLE), .GROUP_COUNT(GCNT), .UNKNOWN_STATE(UNK)) i_dut (
        .sys_clk_in    (sys_clk_in),
        .reset_n_in    (reset_n_in),
        .req_in        (req),
        .req_ready_out (req_ready),
        .resp_out      (resp),
        .resp_ready_in (resp_ready),
        .op_cond_in    (op_cond),
        .state_out     (state)
    );

    osgh_ctrl_model i_ctrl (
        .sys_clk_in     (sys_clk_in),
        .req_ready_in   (req_ready),
        .req_out        (req),
        .resp_ready_out (resp_ready)
    );

    // Free running clock
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("Checks made: %0d, mismatches: %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Accepted byte vs oldest note; negedge sampling avoids the edge race
    always @(negedge sys_clk_in) begin
        if (reset_n_in && resp.valid === 1'b1 && resp_ready === 1'b1) begin
            check({resp.last, resp.data}, exp_q.size() != 0 ? exp_q.pop_front() : 9'bx);
            check({8'h00, req_ready}, 9'h000);
        end
    end

    // Hang guard, far above the expected run length
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            test_done();
        end
    end

    // Send one message, then wait a bounded time for all noted bytes
    task automatic xfer(input logic [7:0] msg[$]);
        int n;
        i_ctrl.send(msg);
        n = 0;
        while (exp_q.size() != 0 && n < 300) begin
            @(posedge sys_clk_in);
            n++;
        end
        if (n == 300) begin
            fails++;
            $display("CHECK FAILED at %0t: response missing", $time);
        end
        repeat (3) @(posedge sys_clk_in);
    endtask

    task automatic do_read(input logic [15:0] h);
        logic en;
        if (h == HANDLE) begin
            exp_q.push_back({1'b0, osgh_pkg::RC_SUCCESS});
            exp_q.push_back({5'h00, GCNT});
            for (int p = 0; p < GCNT; p++) begin
                en = op_cond[p] == osgh_pkg::COND_UPDATE_PENDING_A || op_cond[p] == osgh_pkg::COND_NO_UPDATE_PENDING_B;
                exp_q.push_back({1'b0, op_cond[p]});
                exp_q.push_back({1'b0, en ? exp_st[p] : UNK});
                exp_q.push_back({p == GCNT - 1, en ? exp_st[p] : UNK});
            end
        end else begin
            exp_q.push_back({1'b1, osgh_pkg::RC_UNKNOWN_HANDLE});
        end
        xfer('{osgh_pkg::OPC_READ_STATES, h[7:0], h[15:8]});
    endtask

    // Set with flag/value pairs; states only move on success
    task automatic do_set(input logic [7:0] cnt, input logic [7:0] pairs[$], input logic [7:0] rc);
        logic [7:0] m[$];
        m = '{osgh_pkg::OPC_SET_STATES, HANDLE[7:0], HANDLE[15:8], cnt};
        m = {m, pairs};
        for (int p = 0; p < cnt && rc == osgh_pkg::RC_SUCCESS; p++) begin
            if (pairs[2 * p] == osgh_pkg::FLAG_APPLY_REQUEST) begin
                exp_st[p] = pairs[2 * p + 1];
            end
        end
        exp_q.push_back({1'b1, rc});
        xfer(m);
        for (int p = 0; p < 8; p++) begin
            check({1'b0, state[p]}, {1'b0, exp_st[p]});
        end
    endtask

    // Main sequence
    initial begin
        fails = 0;
        n_checks = 0;
        cycles = 0;
        reset_n_in = 1'b0;
        op_cond = '0;
        foreach (exp_st[p]) exp_st[p] = 8'h00;
        void'($urandom(32'h3f4de4aa));
        repeat (8) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        // Random sets, each read back under a rotating mix of all conditions
        for (int k = 0; k < 8; k++) begin
            i_ctrl.slow_r = k[0];
            fv.delete();
            for (int p = 0; p < GCNT; p++) begin
                fv.push_back(8'($urandom_range(0, 1)));
                fv.push_back(8'($urandom));
            end
            do_set({4'h0, GCNT}, fv, osgh_pkg::RC_SUCCESS);
            for (int p = 0; p < 8; p++) op_cond[p] <= 8'((k + p) % 4);
            @(posedge sys_clk_in);
            do_read(HANDLE);
        end
        // Single record, then refused sets that must leave states alone
        do_set(8'h01, '{osgh_pkg::FLAG_APPLY_REQUEST, 8'hC3}, osgh_pkg::RC_SUCCESS);
        do_set(8'h02, '{8'h01, 8'h11, 8'h02, 8'h22}, osgh_pkg::RC_INVALID_DATA);
        do_set(8'h02, '{8'h01, 8'h33}, osgh_pkg::RC_INVALID_LENGTH);
        // Count above the group size, and a surplus byte after the last record
        do_set(8'h07, '{osgh_pkg::FLAG_APPLY_REQUEST, 8'h44}, osgh_pkg::RC_INVALID_DATA);
        do_set(8'h01, '{osgh_pkg::FLAG_APPLY_REQUEST, 8'h55, 8'h00}, osgh_pkg::RC_INVALID_LENGTH);
        // Reserved and foreign handles, unknown opcode
        do_read(16'h0000);
        do_read(16'hFFFF);
        do_read(HANDLE + 16'h0001);
        exp_q.push_back({1'b1, osgh_pkg::RC_UNSUPPORTED_CMD});
        xfer('{8'h07, HANDLE[7:0], HANDLE[15:8]});
        do_read(HANDLE);
        test_done();
    end
endmodule
